// ### hdl/rsls_sequencer.sv
// rolling shutter line sequencer with apb registers
// Contract
// RULE1: staggered: trigger resets, exposes first line
// RULE2: staggered: next line one line period later
// RULE3: same exposure for all lines, us or raw
// RULE4: staggered: readout at exposure end, one period
// RULE5: reset runtime is period times height minus one
// RULE6: readout time is period times height plus tail
// RULE7: total runtime is exposure plus readout time
// RULE8: staggered: no flash if exposure within reset runtime
// RULE9: line period depends on pixel format
// RULE10: readout tail depends on shutter variant
// RULE11: exposure active from first start to last end
// RULE12: provide a flash window output
// RULE13: release mode: trigger resets all lines together
// RULE14: release mode: ends staggered by line period
// RULE15: release mode: readout at each exposure end
// RULE16: mode from selection setting or enable bit
// RULE17: enable bit clear staggered, set release
// RULE18: release mode: flash from trigger for exposure
// RULE19: flash high while all lines expose
// RULE20: settings as clock counts, counters sequence lines
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "rsls_defines.svh"

module rsls_sequencer
    import rsls_pkg::*;
#(
    parameter int unsigned TAIL_STAG_CYC = `RSLS_TAIL_STAG_US * `RSLS_US_CYC,  // staggered tail, cycles
    parameter int unsigned TAIL_REL_CYC  = `RSLS_TAIL_REL_US * `RSLS_US_CYC    // release tail, cycles
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        frame_trigger_i,   // frame start pin
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             line_reset_o,      // one line reset, pulse
    output logic             line_reset_all_o,  // all lines reset, pulse
    output logic      [11:0] reset_line_o,      // line being reset
    output logic             line_readout_o,    // one line readout start, pulse
    output logic      [11:0] readout_line_o,    // line being read
    output logic             exposure_active_o,
    output logic             flash_window_o,
    output logic             flash_available_o,
    output logic             busy_o
);

    // full product, cut to 32 bits; the counts never get near the top
    function automatic logic [31:0] mul32(input logic [31:0] a, input logic [31:0] b);
        logic [63:0] prod;
        prod = a * b;
        return prod[31:0];
    endfunction : mul32

    rsls_ctrl_s  ctrl;          // control register
    logic [19:0] exp_us;        // exposure_time_us
    logic [19:0] exp_raw;       // exposure_time_raw_count
    logic [11:0] aoi_h;         // area of interest height
    logic [15:0] rom_p;         // line period from table
    rsls_state_e state;         // sequencer state
    rsls_frame_s fr;            // frozen frame values
    logic [31:0] t;             // cycles since trigger
    logic [31:0] next_t;        // frame timer plus one
    logic        trig_s1;       // synchroniser first stage
    logic        trig_s2;       // synchroniser second stage
    logic        trig_s3;       // edge history
    logic        accept;        // trigger taken this cycle
    logic        run;           // frame in progress
    logic        shut_rel;      // release mode selected
    logic        shut_glob;     // global selected: not ours
    logic        shut_stag;     // staggered mode selected
    logic [11:0] h_eff;         // height, zero treated as one
    logic [31:0] p_cyc;         // line period, cycles
    logic [31:0] e_cyc;         // exposure, cycles
    logic [31:0] rrt_cyc;       // reset runtime, cycles
    logic [31:0] tail_cyc;      // readout tail, cycles
    logic [31:0] rdt_cyc;       // total readout time, cycles
    logic [31:0] tot_cyc;       // total runtime, cycles
    logic        avail;         // flash window possible
    logic [15:0] rst_tick;      // reset spacing countdown
    logic        rst_more;      // resets still to issue
    logic [15:0] rd_tick;       // readout spacing countdown
    logic        rd_more;       // readouts still to issue
    logic        wr_en;         // apb write strobe
    logic        setup;         // apb setup cycle
    logic        hit;           // address is mapped

    // line period table, indexed by variant and pixel format
    rsls_period_rom u_rom (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .addr_i ({ctrl.variant, ctrl.pix_fmt}),
        .data_o (rom_p)
    );

    // mode decode: setting or enable bit picks the shutter
    always_comb begin
        if (ctrl.mode_src) begin
            shut_rel  = ctrl.reset_release_enable;                              // RULE17
            shut_glob = 1'b0;
        end else begin
            shut_rel  = (ctrl.shutter_selection == RSLS_SHUT_RELEASE);          // RULE16
            // reserved code counts as global so no frame runs on a bad setting
            shut_glob = (ctrl.shutter_selection != RSLS_SHUT_RELEASE) &&
                        (ctrl.shutter_selection != RSLS_SHUT_STAGGER);          // RULE16
        end
        shut_stag = !shut_rel && !shut_glob;
    end

    // settings turned into clock counts
    always_comb begin
        h_eff = (aoi_h == 12'h000) ? 12'h001 : aoi_h;
        p_cyc = {16'h0000, rom_p};                                              // RULE20
        e_cyc = ctrl.exp_raw ? mul32({12'h000, exp_raw}, `RSLS_RAW_STEP_CYC)
                             : mul32({12'h000, exp_us}, 32'(`RSLS_US_CYC));     // RULE3
        if (e_cyc == 32'h0) begin
            e_cyc = 32'h1;      // a zero exposure would skip the readout start
        end
        rrt_cyc = mul32(p_cyc, {20'h0, h_eff - 12'h001});                       // RULE5
        if (ctrl.variant) begin
            tail_cyc = mul32(p_cyc, (shut_rel ? `RSLS_TAIL_REL_MULT : `RSLS_TAIL_STAG_MULT)
                                    + {31'h0, ctrl.colour});                    // RULE10
        end else begin
            tail_cyc = shut_rel ? TAIL_REL_CYC : TAIL_STAG_CYC;                 // RULE10
        end
        rdt_cyc = mul32(p_cyc, {20'h0, h_eff}) + tail_cyc;                      // RULE6
        tot_cyc = e_cyc + rdt_cyc;                                              // RULE7
        avail   = shut_rel || (e_cyc > rrt_cyc);                                // RULE8
    end

    // trigger pin synchroniser and rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= frame_trigger_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // triggers during a frame or in global mode are dropped
    assign accept = (state == RSLS_IDLE) && trig_s2 && !trig_s3 && !shut_glob;
    assign run    = (state == RSLS_RUN);
    assign next_t = t + 32'h1;
    assign busy_o = run;

    // frame state and timer; settings are frozen at the trigger
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RSLS_IDLE;
            t     <= 32'h0;
            fr    <= '0;
        end else begin
            unique case (state)
                RSLS_IDLE: begin
                    if (accept) begin
                        state <= RSLS_RUN;
                        t     <= 32'h0;
                        fr    <= '{stagger: shut_stag, avail: avail, h: h_eff, p: p_cyc,
                                   e: e_cyc, rrt: rrt_cyc, tot: tot_cyc};       // RULE20
                    end
                end
                RSLS_RUN: begin
                    t <= next_t;
                    if (next_t == fr.tot) begin
                        state <= RSLS_IDLE;                                     // RULE7
                    end
                end
            endcase
        end
    end

    // line resets: staggered line 0 at the trigger, then one per line period; release all lines at the trigger
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_reset_o     <= 1'b0;
            line_reset_all_o <= 1'b0;
            reset_line_o     <= 12'h000;
            rst_tick         <= 16'h0000;
            rst_more         <= 1'b0;
        end else begin
            line_reset_o     <= 1'b0;
            line_reset_all_o <= 1'b0;
            if (accept) begin
                line_reset_o     <= shut_stag;                                  // RULE1
                line_reset_all_o <= shut_rel;                                   // RULE13
                reset_line_o     <= 12'h000;
                rst_tick         <= rom_p - 16'h0001;
                rst_more         <= shut_stag && (h_eff != 12'h001);
            end else if (run && rst_more) begin
                if (rst_tick == 16'h0000) begin
                    line_reset_o <= 1'b1;                                       // RULE2
                    reset_line_o <= reset_line_o + 12'h001;
                    rst_tick     <= fr.p[15:0] - 16'h0001;
                    if (reset_line_o + 12'h001 == fr.h - 12'h001) begin
                        rst_more <= 1'b0;                                       // bottom line reached
                    end
                end else begin
                    rst_tick <= rst_tick - 16'h0001;
                end
            end
        end
    end

    // readouts: first at the exposure end, then one per line period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_readout_o <= 1'b0;
            readout_line_o <= 12'h000;
            rd_tick        <= 16'h0000;
            rd_more        <= 1'b0;
        end else begin
            line_readout_o <= 1'b0;
            if (run && next_t == fr.e) begin
                line_readout_o <= 1'b1;                                         // RULE4 RULE14
                readout_line_o <= 12'h000;
                rd_tick        <= fr.p[15:0] - 16'h0001;
                rd_more        <= (fr.h != 12'h001);
            end else if (run && rd_more) begin
                if (rd_tick == 16'h0000) begin
                    line_readout_o <= 1'b1;                                     // RULE15
                    readout_line_o <= readout_line_o + 12'h001;
                    rd_tick        <= fr.p[15:0] - 16'h0001;
                    if (readout_line_o + 12'h001 == fr.h - 12'h001) begin
                        rd_more <= 1'b0;
                    end
                end else begin
                    rd_tick <= rd_tick - 16'h0001;
                end
            end
        end
    end

    // exposure active: first line start to last line end (same instant in both modes)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            exposure_active_o <= 1'b0;
        end else if (accept) begin
            exposure_active_o <= 1'b1;                                          // RULE11
        end else if (run && next_t == fr.e + fr.rrt) begin
            exposure_active_o <= 1'b0;                                          // RULE11
        end
    end

    // flash window: opens when the last line starts, closes when the first ends
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_window_o <= 1'b0;
        end else if (accept) begin
            // release mode and single-line frames open at the trigger
            flash_window_o <= shut_rel || (avail && rrt_cyc == 32'h0);          // RULE18 RULE19
        end else if (run && next_t == fr.e) begin
            flash_window_o <= 1'b0;                                             // RULE18 RULE19
        end else if (run && fr.stagger && fr.avail && next_t == fr.rrt) begin
            flash_window_o <= 1'b1;                                             // RULE8 RULE12
        end
    end

    // live flag: would the current settings give a flash window
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_available_o <= 1'b0;
        end else begin
            flash_available_o <= avail && !shut_glob;                           // RULE8
        end
    end

    // apb decode; one wait-free access phase, read data captured in the setup cycle, write data in the access phase
    assign setup    = psel_i && !penable_i;
    assign wr_en    = psel_i && penable_i && pwrite_i;
    assign pready_o = psel_i && penable_i;
    assign hit      = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0);

    // writable registers; a change mid-frame counts from the next trigger
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl    <= `RSLS_CTRL_RST;
            exp_us  <= `RSLS_EXP_US_RST;
            exp_raw <= `RSLS_EXP_RAW_RST;
            aoi_h   <= `RSLS_AOI_H_RST;
        end else if (wr_en) begin
            unique case (paddr_i)
                `RSLS_ADDR_CTRL:    ctrl    <= {23'h0, pwdata_i[8:0]};
                `RSLS_ADDR_EXP_US:  exp_us  <= pwdata_i[19:0];
                `RSLS_ADDR_EXP_RAW: exp_raw <= pwdata_i[19:0];
                `RSLS_ADDR_AOI_H:   aoi_h   <= pwdata_i[11:0];
                default:            ;   // read-only or unmapped: write ignored
            endcase
        end
    end

    // read data and error, both registered in the setup cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            pslverr_o <= !hit;
            unique case (paddr_i)
                `RSLS_ADDR_CTRL:      prdata_o <= ctrl;
                `RSLS_ADDR_EXP_US:    prdata_o <= {12'h000, exp_us};
                `RSLS_ADDR_EXP_RAW:   prdata_o <= {12'h000, exp_raw};
                `RSLS_ADDR_AOI_H:     prdata_o <= {20'h00000, aoi_h};
                `RSLS_ADDR_STATUS:    prdata_o <= {4'h0, readout_line_o, 10'h000, shut_glob, shut_rel,
                                                   flash_available_o, flash_window_o,
                                                   exposure_active_o, busy_o};
                `RSLS_ADDR_RESET_RT:  prdata_o <= rrt_cyc;                      // RULE5
                `RSLS_ADDR_READOUT_T: prdata_o <= rdt_cyc;                      // RULE6
                `RSLS_ADDR_TOTAL_RT:  prdata_o <= tot_cyc;                      // RULE7
                default:              prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // checks on the frame sequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence frame_open;
        accept ##1 exposure_active_o;
    endsequence

    first_reset_a: assert property (accept && shut_stag |=> line_reset_o && reset_line_o == 12'h000) // RULE1
        else $error("first line not reset at trigger");
    reset_step_a: assert property (line_reset_o |-> t == mul32(fr.p, {20'h0, reset_line_o})) // RULE2
        else $error("line reset off its line period slot");
    readout_at_a: assert property (line_readout_o |-> t == fr.e + mul32(fr.p, {20'h0, readout_line_o})) // RULE4
        else $error("line readout not at its exposure end");
    exp_open_a: assert property (accept |-> frame_open) // RULE11
        else $error("exposure active did not rise at trigger");
    exp_close_a: assert property ($fell(exposure_active_o) |-> t == fr.e + fr.rrt) // RULE11
        else $error("exposure active fell at wrong time");
    no_flash_a: assert property (run && fr.stagger && !fr.avail |-> !flash_window_o) // RULE8
        else $error("flash window shown without overlap");
    rel_reset_a: assert property (accept && shut_rel |=> line_reset_all_o && !line_reset_o) // RULE13
        else $error("release mode did not reset all lines");
    rel_flash_a: assert property (accept && shut_rel |=> flash_window_o throughout (run && t < fr.e)[*1]) // RULE18
        else $error("release flash window not open at trigger");
    flash_close_a: assert property ($fell(flash_window_o) |-> t == fr.e) // RULE19
        else $error("flash window closed off the exposure end");
    frame_end_a: assert property ($fell(busy_o) |-> t == fr.tot) // RULE7
        else $error("frame ended off its total runtime");
    bit_mode_a: assert property (ctrl.mode_src |-> shut_rel == ctrl.reset_release_enable && !shut_glob) // RULE17
        else $error("enable bit did not pick the mode");

endmodule : rsls_sequencer

// ### hdl/rsls_defines.svh
// constants of the rolling shutter line sequencer: addresses, reset values, timing
`ifndef RSLS_DEFINES_SVH
`define RSLS_DEFINES_SVH

// clock period of clk_i in ns
`define RSLS_CLK_NS          10
// cycles of clk_i per microsecond
`define RSLS_US_CYC          (1000 / `RSLS_CLK_NS)
// cycles per tenth of a microsecond, for line periods printed with one decimal
`define RSLS_US10_TO_CYC(x)  ((x) * 100 / `RSLS_CLK_NS)

// apb register byte addresses
`define RSLS_ADDR_CTRL       8'h00
`define RSLS_ADDR_EXP_US     8'h04
`define RSLS_ADDR_EXP_RAW    8'h08
`define RSLS_ADDR_AOI_H      8'h0c
`define RSLS_ADDR_STATUS     8'h10
`define RSLS_ADDR_RESET_RT   8'h14
`define RSLS_ADDR_READOUT_T  8'h18
`define RSLS_ADDR_TOTAL_RT   8'h1c

// register reset values
`define RSLS_CTRL_RST        32'h0000_0001
`define RSLS_EXP_US_RST      20'h003e8
`define RSLS_EXP_RAW_RST     20'h00064
`define RSLS_AOI_H_RST       12'h010

// line periods in tenths of a microsecond
`define RSLS_LINE_PERIOD_FIX_US10   350
`define RSLS_LINE_PERIOD_8B_US10    316
`define RSLS_LINE_PERIOD_12P_US10   364
`define RSLS_LINE_PERIOD_12B_US10   396
`define RSLS_LINE_PERIOD_FIX_CYC    `RSLS_US10_TO_CYC(`RSLS_LINE_PERIOD_FIX_US10)
`define RSLS_LINE_PERIOD_8B_CYC     `RSLS_US10_TO_CYC(`RSLS_LINE_PERIOD_8B_US10)
`define RSLS_LINE_PERIOD_12P_CYC    `RSLS_US10_TO_CYC(`RSLS_LINE_PERIOD_12P_US10)
`define RSLS_LINE_PERIOD_12B_CYC    `RSLS_US10_TO_CYC(`RSLS_LINE_PERIOD_12B_US10)

// readout tail of the fixed-period variant, in microseconds
`define RSLS_TAIL_STAG_US    490
`define RSLS_TAIL_REL_US     810
// readout tail of the format-dependent variant, in line periods (mono; colour adds one)
`define RSLS_TAIL_STAG_MULT  32'd143
`define RSLS_TAIL_REL_MULT   32'd901

// one raw exposure count in clock cycles
`define RSLS_RAW_STEP_CYC    32'd10

`endif

// ### hdl/rsls_pkg.sv
// types shared by the rolling shutter line sequencer
package rsls_pkg;

    // shutter selection values of the ctrl register
    typedef enum logic [1:0] {
        RSLS_SHUT_GLOBAL,
        RSLS_SHUT_STAGGER,
        RSLS_SHUT_RELEASE
    } rsls_shutter_e;

    // sequencer state
    typedef enum logic {
        RSLS_IDLE,
        RSLS_RUN
    } rsls_state_e;

    // ctrl register layout
    typedef struct packed {
        logic [22:0] pad;        // reads as zero
        logic        exp_raw;    // 1: exposure from raw count
        logic        colour;     // 1: colour sensor
        logic [1:0]  pix_fmt;    // 0: 8 bit, 1: 12 bit packed, 2/3: 12 bit
        logic        variant;    // 1: format-dependent line period
        logic        mode_src;   // 1: mode from reset_release_enable
        logic        reset_release_enable;
        logic [1:0]  shutter_selection;
    } rsls_ctrl_s;

    // values frozen for one frame
    typedef struct packed {
        logic        stagger;    // staggered-start frame
        logic        avail;      // flash window exists
        logic [11:0] h;          // lines in the area of interest
        logic [31:0] p;          // line period in cycles
        logic [31:0] e;          // exposure in cycles
        logic [31:0] rrt;        // reset runtime in cycles
        logic [31:0] tot;        // total runtime in cycles
    } rsls_frame_s;

endpackage : rsls_pkg

// ### hdl/rsls_period_rom.sv
// line period lookup table with registered read data
`timescale 1ns/1ps
`include "rsls_defines.svh"

module rsls_period_rom (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  addr_i,   // {variant, pixel format}
    output logic      [15:0] data_o    // line period in cycles
);

    // one entry per variant and pixel format; read data lands one cycle later
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 16'h0000;
        end else begin
            unique case (addr_i)
                3'h4:    data_o <= 16'(`RSLS_LINE_PERIOD_8B_CYC);   // RULE9
                3'h5:    data_o <= 16'(`RSLS_LINE_PERIOD_12P_CYC);  // RULE9
                3'h6,
                3'h7:    data_o <= 16'(`RSLS_LINE_PERIOD_12B_CYC);  // RULE9
                default: data_o <= 16'(`RSLS_LINE_PERIOD_FIX_CYC);  // fixed period for every format
            endcase
        end
    end

endmodule : rsls_period_rom

// ### bench/rsls_line_array.sv
// pixel line array model: stamps the cycle of every line event of a frame
`timescale 1ns/1ps
module rsls_line_array (
    input wire logic        clk_i,
    input wire logic        rst_one_i,   // one line reset
    input wire logic        rst_all_i,   // all lines reset
    input wire logic [11:0] rst_line_i,
    input wire logic        rd_i,        // readout start
    input wire logic [11:0] rd_line_i,
    input wire logic        exp_i,
    input wire logic        fl_i,
    input wire logic        busy_i
);
    int unsigned cyc, ev[8], n_rst, n_rd, n_fl;  // event stamps and counts
    logic        exp_q, fl_q, busy_q;            // last levels seen
    // a frame start clears the log first, so a flash opening at once still counts
    always @(posedge clk_i) begin
        cyc++;
        if (rst_all_i || (rst_one_i && rst_line_i == 12'h000)) begin
            ev[0] = cyc;
            n_rst = 0;
            n_rd = 0;
            n_fl = 0;
        end
        if (rst_one_i || rst_all_i) begin
            ev[1] = cyc;
            n_rst++;
        end
        if (rd_i) begin
            if (rd_line_i == 12'h000) ev[2] = cyc;
            ev[3] = cyc;
            n_rd++;
        end
        if (!exp_i && exp_q) ev[4] = cyc;
        if (fl_i && !fl_q) begin
            ev[5] = cyc;
            n_fl++;
        end
        if (!fl_i && fl_q) ev[6] = cyc;
        if (!busy_i && busy_q) ev[7] = cyc;
        exp_q = exp_i;
        fl_q = fl_i;
        busy_q = busy_i;
    end
endmodule : rsls_line_array

// ### bench/tb_rsls_sequencer.sv
// testbench of the rolling shutter line sequencer
`timescale 1ns/1ps
`include "rsls_defines.svh"
module tb_rsls_sequencer;
    localparam int unsigned TS = 20, TR = 40, P = `RSLS_LINE_PERIOD_FIX_CYC;  // short tails keep frames brief
    logic clk_i = 0, rst_i = 1, trig = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, per[3];
    logic        pready, pslverr, lr, lra, lro, xa, fw, fa, busy, er;
    logic [11:0] rl, rol;
    int          num_errors = 0, n_tests = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    rsls_sequencer #(.TAIL_STAG_CYC(TS), .TAIL_REL_CYC(TR)) rsls_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
        .frame_trigger_i(trig), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_reset_o(lr),
        .line_reset_all_o(lra), .reset_line_o(rl), .line_readout_o(lro), .readout_line_o(rol),
        .exposure_active_o(xa), .flash_window_o(fw), .flash_available_o(fa), .busy_o(busy));
    rsls_line_array la (.clk_i(clk_i), .rst_one_i(lr), .rst_all_i(lra), .rst_line_i(rl), .rd_i(lro),
        .rd_line_i(rol), .exp_i(xa), .fl_i(fw), .busy_i(busy));
    task summarize;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // hang guard: four frames need about 44000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            summarize();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task wt(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 30000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk({31'h0, busy}, {31'h0, v});
    endtask : wt
    // defaults, derived times, line period table, unmapped address
    task t_regs;
        apb(0, `RSLS_ADDR_RESET_RT, 0);
        chk(rd, P * 15);
        apb(0, `RSLS_ADDR_TOTAL_RT, 0);
        chk(rd, 100000 + P * 16 + TS);
        apb(0, 8'h20, 0);
        chk({31'h0, er}, 32'h1);
        apb(1, `RSLS_ADDR_AOI_H, 2);
        apb(0, `RSLS_ADDR_AOI_H, 0);
        chk(rd, 32'h2);
        for (int f = 0; f < 3; f++) begin
            apb(1, `RSLS_ADDR_CTRL, 32'h11 | (f << 5));
            apb(0, `RSLS_ADDR_RESET_RT, 0);
            chk(rd, per[f]);
        end
        apb(0, `RSLS_ADDR_READOUT_T, 0);
        chk(rd, 145 * per[2]);
    endtask : t_regs
    // one two-line frame; event spacing judged from the line array log
    task t_frame(input logic [31:0] ctrl, input logic [31:0] raw, input logic rel, input logic fl);
        int unsigned e;
        e = raw * `RSLS_RAW_STEP_CYC;
        apb(1, `RSLS_ADDR_EXP_RAW, raw);
        apb(1, `RSLS_ADDR_CTRL, ctrl | 32'h100);
        apb(0, `RSLS_ADDR_STATUS, 0);
        chk({30'h0, rd[4:3]}, {30'h0, rel, fl});
        chk({31'h0, fa}, {31'h0, fl});
        trig <= 1;
        repeat (4) @(posedge clk_i);
        trig <= 0;
        wt(1);
        wt(0);
        // the line array stamps the busy fall one edge later; let it land first
        repeat (2) @(posedge clk_i);
        chk(la.ev[1] - la.ev[0], rel ? 0 : P);
        chk(la.n_rst, rel ? 1 : 2);
        chk(la.ev[2] - la.ev[0], e);
        chk(la.ev[3] - la.ev[2], P);
        chk(la.n_rd, 2);
        chk(la.ev[4] - la.ev[0], e + P);
        chk(la.n_fl, {31'h0, fl});
        if (fl) begin
            chk(la.ev[5] - la.ev[0], rel ? 0 : P);
            chk(la.ev[6] - la.ev[0], e);
        end
        chk(la.ev[7] - la.ev[0], e + 2 * P + (rel ? TR : TS));
    endtask : t_frame
    initial begin
        per = '{`RSLS_LINE_PERIOD_8B_CYC, `RSLS_LINE_PERIOD_12P_CYC, `RSLS_LINE_PERIOD_12B_CYC};
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_frame(32'h1, 500, 0, 1);
        t_frame(32'h8, 350, 0, 0);
        t_frame(32'h2, 500, 1, 1);
        t_frame(32'hc, 200, 1, 1);
        apb(1, `RSLS_ADDR_CTRL, 0);
        trig <= 1;
        repeat (10) @(posedge clk_i);
        chk({31'h0, busy}, 32'h0);
        summarize();
    end
endmodule : tb_rsls_sequencer
